/* File: shared/ppc_pkg.sv */
// Constants for the process-control loop
package ppc_pkg;
    localparam int          PV_W             = 12;
    localparam int          PCT_W            = 10;
    localparam int          CMD_W            = 16;
    localparam int          NUM_IN           = 7;
    localparam int          NUM_OUT          = 3;
    localparam logic [13:0] ACT_OFF          = 14'h0000;
    localparam logic [13:0] ACT_PV_REV       = 14'h0014;
    localparam logic [13:0] ACT_PV_FWD       = 14'h0015;
    localparam logic [13:0] ACT_DEV_REV      = 14'h0032;
    localparam logic [13:0] ACT_DEV_FWD      = 14'h0033;
    localparam logic [13:0] ACT_NET_REV      = 14'h003C;
    localparam logic [13:0] ACT_NET_FWD      = 14'h003D;
    localparam logic [13:0] SET_NONE         = 14'h270F;
    localparam logic [7:0]  IN_LOOP_SEL      = 8'h0E;
    localparam logic [7:0]  OUT_LOWER        = 8'h0E;
    localparam logic [7:0]  OUT_UPPER        = 8'h0F;
    localparam logic [7:0]  OUT_DIR          = 8'h10;
    localparam logic [7:0]  OUT_ACTIVE       = 8'h2F;
    localparam logic [7:0]  OUT_NEG_BASE     = 8'h64;
    localparam logic [7:0]  ANA_5V_A         = 8'h01;
    localparam logic [7:0]  ANA_5V_B         = 8'h0B;
    localparam logic [1:0]  RANGE_4_20MA     = 2'h0;
    localparam logic [1:0]  RANGE_5V         = 2'h1;
    localparam logic [1:0]  RANGE_10V        = 2'h2;
    localparam logic [11:0] ADC_FULL         = 12'hFFF;
    localparam logic [11:0] ADC_HALF         = 12'h7FF;
    localparam logic [11:0] ADC_4MA          = 12'h333;
    localparam logic [9:0]  PCT_FULL         = 10'h3E8;
    localparam int          UPDATE_NS        = 1000;
    localparam int          CLK_NS           = 8;
    localparam int          UPDATE_CYC       = UPDATE_NS / CLK_NS;
    localparam logic [7:0]  UPDATE_CYC_M1    = 8'(UPDATE_CYC - 1);
endpackage : ppc_pkg

/* File: rtl/ppc_pid_unit.sv */
// Process-control loop: source select, PID computation, limit and status flags
//
// How it works
// - Reverse action: positive deviation raises command, negative lowers it.
// - Forward action: negative deviation raises command, positive lowers it.
// - Output is sum of P, I and D terms; PD variant omits I.
// - Loop runs only for action codes 20, 21, 50, 51, 60, 61.
// - Input function code 14 maps that input to loop select; high enables.
// - With no input mapped, a valid action code alone enables the loop.
// - Action code 0 or loop select low gives normal frequency control.
// - Codes 20/21: set point from terminal 2 if setting 9999, else stored.
// - Terminal 4 scaled from 4-20mA, 0-5V or 0-10V by range setting.
// - Codes 50/51 use the network-supplied deviation directly.
// - Codes 60/61 use network-supplied set point and process value.
// - Upper flag (codes 20/21/60/61) when process value exceeds limit, limit not 9999.
// - Lower flag (codes 20/21/60/61) when process value below limit, limit not 9999.
// - Direction output high only while rotating forward.
// - Loop-active output high while closed-loop control operates.
// - Output function codes 100 and above drive inverted logic.
// - Network master may set or clear the mapped loop-select bit.
// - Entering closed loop starts the command from 0Hz.
`timescale 1ns/1ps
module ppc_pid_unit #(
    parameter int KP_SH = 2,
    parameter int KI_SH = 6,
    parameter int KD_SH = 3
) (
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic [13:0]             action_select_setting_in,
    input  wire logic [13:0]             upper_limit_setting_in,
    input  wire logic [13:0]             lower_limit_setting_in,
    input  wire logic [13:0]             set_point_setting_in,
    input  wire logic [7:0]              analog_select_setting_in,
    input  wire logic [1:0]              measured_range_setting_in,
    input  wire logic [8*ppc_pkg::NUM_IN-1:0]  input_function_selects_in,
    input  wire logic [8*ppc_pkg::NUM_OUT-1:0] output_function_selects_in,
    input  wire logic                    pd_only_in,
    input  wire logic [ppc_pkg::NUM_IN-1:0]    input_terminals_in,
    input  wire logic [ppc_pkg::NUM_IN-1:0]    net_input_bits_in,
    input  wire logic                    net_input_ctrl_in,
    input  wire logic [11:0]             terminal2_in,
    input  wire logic [11:0]             terminal4_in,
    input  wire logic signed [10:0]      net_deviation_in,
    input  wire logic [9:0]              net_set_point_in,
    input  wire logic [9:0]              net_process_in,
    input  wire logic                    run_forward_in,
    input  wire logic                    run_reverse_in,
    output logic [ppc_pkg::NUM_OUT-1:0]  output_terminals_out,
    output logic [ppc_pkg::CMD_W-1:0]    freq_command_out,
    output logic                         loop_active_out
);
    localparam int NI = ppc_pkg::NUM_IN;
    localparam int NO = ppc_pkg::NUM_OUT;

    typedef struct packed {
        logic [NI-1:0]        term_s1;
        logic [NI-1:0]        term_s2;
        logic [1:0]           dir_s1;
        logic [1:0]           dir_s2;
        logic [11:0]          t2_s1;
        logic [11:0]          t2_s2;
        logic [11:0]          t4_s1;
        logic [11:0]          t4_s2;
        logic [7:0]           tick_cnt;
        logic                 active;
        logic signed [11:0]   dev_prev;
        logic signed [23:0]   integ;
        logic [15:0]          cmd;
        logic                 upper;
        logic                 lower;
        logic [NO-1:0]        outs;
    } ppc_state_t;

    ppc_state_t state_reg;
    ppc_state_t state_next;

    // Scales an ADC code between a floor and full scale to 0..1000
    function automatic logic [9:0] ppc_scale(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
        logic [21:0] num;
        num = 22'h000000;
        if (v <= lo) begin
            return 10'h000;
        end
        if (v >= hi) begin
            return ppc_pkg::PCT_FULL;
        end
        num = 22'(v - lo) * 22'(ppc_pkg::PCT_FULL);
        return 10'(num / 22'(hi - lo));
    endfunction : ppc_scale

    // True when a limit setting in tenths of percent is in use, i.e. not 9999
    function automatic logic lim_on(input logic [13:0] s);
        return (s != ppc_pkg::SET_NONE);
    endfunction : lim_on

    logic               code_ok;
    logic               is_fwd;
    logic               mapped;
    logic               sel_level;
    logic               loop_en;
    logic [9:0]         sp_pct;
    logic [9:0]         pv_pct;
    logic [9:0]         t2_pct;
    logic [9:0]         t4_pct;
    logic signed [11:0] dev;
    logic signed [11:0] dev_dir;
    logic signed [23:0] p_term;
    logic signed [23:0] d_term;
    logic signed [23:0] mv;
    logic               tick;
    logic               dir_fwd;
    logic [NI-1:0]      src_bits;

    always_comb begin
        code_ok = (action_select_setting_in == ppc_pkg::ACT_PV_REV) ||
                  (action_select_setting_in == ppc_pkg::ACT_PV_FWD) ||
                  (action_select_setting_in == ppc_pkg::ACT_DEV_REV) ||
                  (action_select_setting_in == ppc_pkg::ACT_DEV_FWD) ||
                  (action_select_setting_in == ppc_pkg::ACT_NET_REV) ||
                  (action_select_setting_in == ppc_pkg::ACT_NET_FWD);
        is_fwd  = action_select_setting_in[0];
        src_bits = net_input_ctrl_in ? net_input_bits_in : state_reg.term_s2;
        mapped = 1'b0;
        sel_level = 1'b0;
        for (int i = 0; i < NI; i++) begin
            if (input_function_selects_in[8*i +: 8] == ppc_pkg::IN_LOOP_SEL) begin
                mapped = 1'b1;
                sel_level = sel_level | src_bits[i];
            end
        end
        loop_en = code_ok && (!mapped || sel_level);
        if (analog_select_setting_in == ppc_pkg::ANA_5V_A ||
            analog_select_setting_in == ppc_pkg::ANA_5V_B) begin
            t2_pct = ppc_scale(state_reg.t2_s2, 12'h000, ppc_pkg::ADC_HALF);
        end else begin
            t2_pct = ppc_scale(state_reg.t2_s2, 12'h000, ppc_pkg::ADC_FULL);
        end
        unique case (measured_range_setting_in)
            ppc_pkg::RANGE_4_20MA: t4_pct = ppc_scale(state_reg.t4_s2, ppc_pkg::ADC_4MA, ppc_pkg::ADC_FULL);
            ppc_pkg::RANGE_5V:     t4_pct = ppc_scale(state_reg.t4_s2, 12'h000, ppc_pkg::ADC_HALF);
            default:               t4_pct = ppc_scale(state_reg.t4_s2, 12'h000, ppc_pkg::ADC_FULL);
        endcase
        if (action_select_setting_in == ppc_pkg::ACT_NET_REV ||
            action_select_setting_in == ppc_pkg::ACT_NET_FWD) begin
            sp_pct = net_set_point_in;
            pv_pct = net_process_in;
        end else begin
            sp_pct = (set_point_setting_in == ppc_pkg::SET_NONE) ? t2_pct : set_point_setting_in[9:0];
            pv_pct = t4_pct;
        end
        if (action_select_setting_in == ppc_pkg::ACT_DEV_REV ||
            action_select_setting_in == ppc_pkg::ACT_DEV_FWD) begin
            dev = 12'(net_deviation_in);
        end else begin
            dev = $signed({2'b00, sp_pct}) - $signed({2'b00, pv_pct});
        end
        dev_dir = is_fwd ? -dev : dev;
        p_term = 24'(dev_dir) <<< KP_SH;
        d_term = (24'(dev_dir) - 24'(state_reg.dev_prev)) <<< KD_SH;
        mv = pd_only_in ? (p_term + d_term) : (p_term + d_term + (state_reg.integ >>> KI_SH));
        tick = (state_reg.tick_cnt == ppc_pkg::UPDATE_CYC_M1);
        dir_fwd = state_reg.dir_s2[0] && !state_reg.dir_s2[1];

        state_next = state_reg;
        state_next.term_s1 = input_terminals_in;
        state_next.term_s2 = state_reg.term_s1;
        state_next.dir_s1  = {run_reverse_in, run_forward_in};
        state_next.dir_s2  = state_reg.dir_s1;
        state_next.t2_s1   = terminal2_in;
        state_next.t2_s2   = state_reg.t2_s1;
        state_next.t4_s1   = terminal4_in;
        state_next.t4_s2   = state_reg.t4_s1;
        state_next.tick_cnt = tick ? 8'h00 : state_reg.tick_cnt + 8'h01;
        state_next.active  = loop_en;
        if (!loop_en) begin
            state_next.integ    = 24'h000000;
            state_next.dev_prev = 12'h000;
            state_next.cmd      = 16'h0000;
            state_next.upper    = 1'b0;
            state_next.lower    = 1'b0;
        end else if (tick) begin
            state_next.dev_prev = dev_dir;
            if (!pd_only_in) begin
                state_next.integ = state_reg.integ + 24'(dev_dir);
            end
            state_next.cmd = mv[23] ? 16'h0000 : (|mv[22:16] ? 16'hFFFF : mv[15:0]);
            if (action_select_setting_in != ppc_pkg::ACT_DEV_REV &&
                action_select_setting_in != ppc_pkg::ACT_DEV_FWD) begin
                state_next.upper = lim_on(upper_limit_setting_in) &&
                                   (14'(pv_pct) > upper_limit_setting_in);
                state_next.lower = lim_on(lower_limit_setting_in) &&
                                   (14'(pv_pct) < lower_limit_setting_in);
            end else begin
                state_next.upper = 1'b0;
                state_next.lower = 1'b0;
            end
        end
        for (int j = 0; j < NO; j++) begin
            logic [7:0] fc;
            logic [7:0] base;
            logic       v;
            fc = output_function_selects_in[8*j +: 8];
            base = (fc >= ppc_pkg::OUT_NEG_BASE) ? fc - ppc_pkg::OUT_NEG_BASE : fc;
            v = 1'b0;
            if (base == ppc_pkg::OUT_UPPER) v = state_reg.upper;
            if (base == ppc_pkg::OUT_LOWER) v = state_reg.lower;
            if (base == ppc_pkg::OUT_DIR) v = dir_fwd;
            if (base == ppc_pkg::OUT_ACTIVE) v = state_reg.active;
            state_next.outs[j] = (fc >= ppc_pkg::OUT_NEG_BASE) ? !v : v;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign output_terminals_out = state_reg.outs;
    assign freq_command_out     = state_reg.cmd;
    assign loop_active_out      = state_reg.active;

    // Leaving the loop, entering it, first update after entry
    sequence s_loop_off;
        !loop_en;
    endsequence

    sequence s_loop_on;
        loop_en;
    endsequence

    sequence s_fresh_tick;
        loop_en && tick && state_reg.dev_prev == 12'h000 && state_reg.integ == 24'h000000;
    endsequence

    // Loop enable and flag gating
    a_bad_code_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !code_ok |=> !loop_active_out)
        else $error("Loop active with invalid code");
    a_off_zero_cmd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !loop_en |=> freq_command_out == 16'h0000)
        else $error("Command not zero when off");
    a_active_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        loop_en |=> loop_active_out)
        else $error("Active not set");
    a_sel_gate_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (mapped && !sel_level) |=> !loop_active_out)
        else $error("Loop with select low");
    a_unmapped_on: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (code_ok && !mapped) |=> loop_active_out)
        else $error("Unmapped loop off");
    a_upper_none: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (tick && upper_limit_setting_in == ppc_pkg::SET_NONE) |=> !state_reg.upper)
        else $error("Upper set");
    a_lower_none: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (tick && lower_limit_setting_in == ppc_pkg::SET_NONE) |=> !state_reg.lower)
        else $error("Lower set");
    a_flag_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (loop_en && !tick && $past(loop_en)) |=> $stable(state_reg.upper))
        else $error("Flag moved off tick");

    // Direction of action, restart from zero and PD integral hold
    a_reentry_base: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_loop_off ##1 s_loop_on |-> freq_command_out == 16'h0000 && state_reg.integ == 24'h000000)
        else $error("Loop entry not from zero");
    a_rev_raise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fresh_tick ##0 (!is_fwd && dev > 12'sh000) |=> freq_command_out != 16'h0000)
        else $error("Reverse action did not raise command");
    a_rev_lower: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fresh_tick ##0 (!is_fwd && dev < 12'sh000) |=> freq_command_out == 16'h0000)
        else $error("Reverse action did not lower command");
    a_fwd_raise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fresh_tick ##0 (is_fwd && dev < 12'sh000) |=> freq_command_out != 16'h0000)
        else $error("Forward action did not raise command");
    a_fwd_lower: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_fresh_tick ##0 (is_fwd && dev > 12'sh000) |=> freq_command_out == 16'h0000)
        else $error("Forward action did not lower command");
    a_pd_no_integ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (loop_en && tick && pd_only_in) |=> $stable(state_reg.integ))
        else $error("Integral moved in PD mode");

    // Flag suppression for codes 50/51 and output terminal mapping
    a_dev_no_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (tick && (action_select_setting_in == ppc_pkg::ACT_DEV_REV ||
                  action_select_setting_in == ppc_pkg::ACT_DEV_FWD)) |=> !state_reg.upper && !state_reg.lower)
        else $error("Limit flag with network deviation");
    a_dir_plain: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (output_function_selects_in[23:16] == ppc_pkg::OUT_DIR) |=> output_terminals_out[2] == $past(dir_fwd))
        else $error("Direction terminal wrong");
    a_dir_inverted: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (output_function_selects_in[23:16] == 8'(ppc_pkg::OUT_NEG_BASE + ppc_pkg::OUT_DIR))
        |=> output_terminals_out[2] == !$past(dir_fwd))
        else $error("Inverted direction terminal wrong");
    a_lower_inverted: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (output_function_selects_in[15:8] == 8'(ppc_pkg::OUT_NEG_BASE + ppc_pkg::OUT_LOWER))
        |=> output_terminals_out[1] == !$past(state_reg.lower))
        else $error("Inverted lower terminal wrong");
    a_active_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (output_function_selects_in[23:16] == ppc_pkg::OUT_ACTIVE) |=> output_terminals_out[2] == $past(loop_active_out))
        else $error("Active terminal wrong");
endmodule : ppc_pid_unit

/* File: testbench/ppc_process_partner.sv */
// Process sensor and field network controller model facing the loop
`timescale 1ns/1ps
module ppc_process_partner (
    input  wire logic [1:0]         range_in,
    input  wire logic               ana_5v_in,
    input  wire logic [9:0]         pv_pct_in,
    input  wire logic [9:0]         sp_pct_in,
    input  wire logic signed [10:0] dev_in,
    output logic [11:0]             terminal2_out,
    output logic [11:0]             terminal4_out,
    output logic [9:0]              net_set_point_out,
    output logic [9:0]              net_process_out,
    output logic signed [10:0]      net_deviation_out
);
    int pv;
    int sp;
    int full;
    int half;
    int low;
    always_comb begin
        pv   = int'(pv_pct_in);
        sp   = int'(sp_pct_in);
        full = int'(ppc_pkg::ADC_FULL);
        half = int'(ppc_pkg::ADC_HALF);
        low  = int'(ppc_pkg::ADC_4MA);
        case (range_in)
            ppc_pkg::RANGE_4_20MA: terminal4_out = 12'(low + pv * (full - low) / int'(ppc_pkg::PCT_FULL));
            ppc_pkg::RANGE_5V:     terminal4_out = 12'(pv * half / int'(ppc_pkg::PCT_FULL));
            default:               terminal4_out = 12'(pv * full / int'(ppc_pkg::PCT_FULL));
        endcase
        terminal2_out     = 12'(sp * (ana_5v_in ? half : full) / int'(ppc_pkg::PCT_FULL));
        net_set_point_out = sp_pct_in;
        net_process_out   = pv_pct_in;
        net_deviation_out = dev_in;
    end
endmodule : ppc_process_partner

/* File: testbench/test_pid_process_control.sv */
// Self-checking bench for the process-control loop
`timescale 1ns/1ps
module test_pid_process_control;
    logic               clk_in = 1'b0;
    logic               sys_rst_in = 1'b1;
    logic [13:0]        act = '0, upl = '0, lowl = '0, sps = '0;
    logic [7:0]         ana = '0;
    logic [1:0]         rng = '0;
    logic [55:0]        ifs = '0;
    logic [23:0]        ofs = '0;
    logic               pd = 1'b0, nctl = 1'b0, fwd = 1'b0, rev = 1'b0;
    logic [6:0]         pins = '0, nbits = '0;
    logic [9:0]         pv = '0, sp = '0, nsp, npv;
    logic signed [10:0] dev = '0, ndev;
    logic [11:0]        t2, t4;
    logic [2:0]         term;
    logic [15:0]        cmd;
    logic               active;
    int                 error_cnt = 0;
    int                 check_count = 0;
    always #4 clk_in = ~clk_in;
    ppc_process_partner u_partner (.range_in(rng), .ana_5v_in(ana == ppc_pkg::ANA_5V_A || ana == ppc_pkg::ANA_5V_B),
        .pv_pct_in(pv),
        .sp_pct_in(sp), .dev_in(dev), .terminal2_out(t2), .terminal4_out(t4), .net_set_point_out(nsp),
        .net_process_out(npv), .net_deviation_out(ndev));
    ppc_pid_unit u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .action_select_setting_in(act),
        .upper_limit_setting_in(upl), .lower_limit_setting_in(lowl), .set_point_setting_in(sps),
        .analog_select_setting_in(ana), .measured_range_setting_in(rng), .input_function_selects_in(ifs),
        .output_function_selects_in(ofs), .pd_only_in(pd), .input_terminals_in(pins),
        .net_input_bits_in(nbits), .net_input_ctrl_in(nctl), .terminal2_in(t2), .terminal4_in(t4),
        .net_deviation_in(ndev), .net_set_point_in(nsp), .net_process_in(npv), .run_forward_in(fwd),
        .run_reverse_in(rev), .output_terminals_out(term), .freq_command_out(cmd), .loop_active_out(active));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic results();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // Reference flag model in tenths of percent
    function automatic logic lim(input int a, input int l, input int v, input bit up);
        if (l == 9999 || !(a inside {20, 21, 60, 61})) return 1'b0;
        return up ? v > l : v < l;
    endfunction : lim
    // Leave the loop, re-enter with new values, judge the command after 400 cycles (three or four ticks)
    task automatic run_cmd(input int a, input int s, input int p, input int d, input logic e);
        act = '0;
        cyc(130);
        check(cmd, '0);
        act = 14'(a);
        sp = 10'(s);
        pv = 10'(p);
        dev = 11'(d);
        cyc(400);
        check(16'(cmd != '0), 16'(e));
    endtask : run_cmd
    initial begin
        static int codes[9] = '{0, 20, 21, 50, 51, 60, 61, 22, 99};
        int a, u, l, v;
        void'($urandom(86));
        cyc(2);
        sys_rst_in = 1'b0;
        cyc(1);
        check(cmd, '0);
        check(16'(term), '0);
        check(16'(active), '0);
        foreach (codes[i]) begin
            act = 14'(codes[i]);
            cyc(2);
            check(16'(active), 16'(codes[i] inside {20, 21, 50, 51, 60, 61}));
        end
        act = 14'h0014;
        ifs[31:24] = ppc_pkg::IN_LOOP_SEL;
        for (int k = 0; k < 8; k++) begin
            {pins[3], nctl, nbits[3]} = 3'(k);
            cyc(5);
            check(16'(active), 16'(nctl ? nbits[3] : pins[3]));
        end
        ifs = '0;
        nctl = 1'b0;
        ofs = {ppc_pkg::OUT_ACTIVE, 8'h72, ppc_pkg::OUT_UPPER};
        repeat (10) begin
            a = ($urandom % 2) ? 60 : 50;
            u = ($urandom % 4 == 0) ? 9999 : 200 + $urandom % 600;
            l = ($urandom % 4 == 0) ? 9999 : 200 + $urandom % 600;
            v = $urandom % 1000;
            v = (v == u || v == l) ? v + 1 : v;
            act = 14'(a);
            upl = 14'(u);
            lowl = 14'(l);
            pv = 10'(v);
            cyc(300);
            check(16'(term), 16'({1'b1, ~lim(a, l, v, 0), lim(a, u, v, 1)}));
        end
        act = 14'h0014;
        upl = 14'h01F4;
        lowl = 14'h012C;
        for (int k = 0; k < 6; k++) begin
            rng = 2'(k / 2);
            v = k[0] ? 900 : 100;
            pv = 10'(v);
            cyc(300);
            check(16'(term), 16'({1'b1, ~lim(20, 300, v, 0), lim(20, 500, v, 1)}));
        end
        for (int k = 0; k < 8; k++) begin
            fwd = k[0];
            rev = k[1] & ~k[0];
            ofs[23:16] = k[2] ? 8'h74 : ppc_pkg::OUT_DIR;
            cyc(130);
            check(16'(term[2]), 16'(k[0] ^ k[2]));
        end
        run_cmd(60, 800, 200, 0, 1'b1);
        run_cmd(60, 200, 800, 0, 1'b0);
        run_cmd(61, 200, 800, 0, 1'b1);
        run_cmd(61, 800, 200, 0, 1'b0);
        run_cmd(50, 0, 0, 300, 1'b1);
        run_cmd(51, 0, 0, 300, 1'b0);
        pd = 1'b1;
        run_cmd(60, 800, 200, 0, 1'b1);
        pd = 1'b0;
        ana = ppc_pkg::ANA_5V_A;
        rng = ppc_pkg::RANGE_10V;
        sps = ppc_pkg::SET_NONE;
        run_cmd(20, 1000, 500, 0, 1'b1);
        sps = 14'h0064;
        run_cmd(20, 1000, 500, 0, 1'b0);
        results();
    end
endmodule : test_pid_process_control
